/* File: pdc_pkg.sv */
// pdc_pkg: shared constants, types and helpers for the power-down link.
// assumes both ends compile against this package first.
package pdc_pkg;

  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int CLK_PS  = 8000;
  // divider must be a power of two
  localparam int CK_DIV  = 8;
  localparam int CK_HALF = CK_DIV / 2;
  localparam int PH_W    = $clog2(CK_DIV);
  localparam int CK_PS   = CLK_PS * CK_DIV;

  // ---------------------------------------------------------------
  // timing, in link clock periods unless named _PS; CNT_W is the counter width in bits
  // ---------------------------------------------------------------
  localparam int CL_CK      = 4;
  localparam int BL_CK      = 4;
  localparam int RPST_CK    = 1;
  localparam int WL_CK      = CL_CK - 1;
  localparam int T_WR_PS    = 15000;
  localparam int T_WTR_PS   = 7500;
  localparam int WR_CK      = (T_WR_PS + CK_PS - 1) / CK_PS;
  localparam int WTR_RAW_CK = (T_WTR_PS + CK_PS - 1) / CK_PS;
  localparam int WTR_CK     = (WTR_RAW_CK > 2) ? WTR_RAW_CK : 2;
  localparam int REC_CK     = (WR_CK > WTR_CK) ? WR_CK : WTR_CK;
  localparam int RD_DONE_CK = CL_CK + BL_CK + RPST_CK;
  localparam int WR_DONE_CK = WL_CK + BL_CK + REC_CK;
  localparam int WR_RD_CK   = WL_CK + BL_CK + WTR_CK;
  localparam int XP_CK      = 2;
  localparam int XARD_CK    = 2;
  localparam int XARDS_CK   = 7;
  localparam int MRD_CK     = 2;
  localparam int CKE_MIN_CK = 3;
  localparam int XSRD_CK    = 200;
  localparam int T_XSNR_PS  = 137500;
  localparam int XSNR_CK    = (T_XSNR_PS + CK_PS - 1) / CK_PS;
  localparam int T_REFI_PS  = 7812500;
  // longest stay, rounded down
  localparam int REFI_CK    = T_REFI_PS / CK_PS;
  localparam int CNT_W      = 8;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic       RST_CKE  = 1'b1;
  localparam logic [1:0] MR_BANK  = 2'h0;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DES  = 4'hF;
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_LM   = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_PRE_PD, ST_ACT_PD, ST_SELF_REF
  } pdc_state_type;

  typedef enum logic [1:0] {M_RUN, M_PD, M_SR} pdc_mode_type;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF, OP_LM,
    OP_PD_ENTER, OP_PD_EXIT, OP_SR_ENTER, OP_SR_EXIT
  } pdc_op_type;

  typedef struct packed {
    logic       ck;
    logic       cke;
    logic [3:0] cmd_n;
    logic [1:0] ba;
    logic       a10;
    logic       a12;
    logic       odt;
  } pdc_pins_type;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic pdc_is_nop(input logic [3:0] cmd_n);
    return cmd_n[3] || (cmd_n == CMD_NOP);
  endfunction : pdc_is_nop

  function automatic pdc_state_type pdc_state_of(input pdc_mode_type m,
                                                 input logic any_open);
    pdc_state_type s;
    s = any_open ? ST_ACTIVE : ST_IDLE;
    if (m == M_PD) s = any_open ? ST_ACT_PD : ST_PRE_PD;
    if (m == M_SR) s = ST_SELF_REF;
    return s;
  endfunction : pdc_state_of

  // count down by one, never below a fresh load
  function automatic logic [CNT_W-1:0] pdc_step(input logic [CNT_W-1:0] c,
                                                input int load);
    logic [CNT_W-1:0] d;
    d = (c == '0) ? c : c - CNT_W'(1);
    return (CNT_W'(load) > d) ? CNT_W'(load) : d;
  endfunction : pdc_step

endpackage : pdc_pkg

/* File: pdc_link_if.sv */
// pdc_link_if: pins between controller end and memory end.
// assumes the controller drives every pin; no two-way pins here.
interface pdc_link_if;
  logic       ck;
  logic       cke;
  logic [3:0] cmd_n;
  logic [1:0] ba;
  logic       a10;
  logic       a12;
  logic       odt;

  modport ctrl (output ck, cke, cmd_n, ba, a10, a12, odt);
  modport dram (input  ck, cke, cmd_n, ba, a10, a12, odt);
endinterface : pdc_link_if

/* File: pdc_dram_end.sv */
// pdc_dram_end: memory-side tracking of power states on the link.
// assumes the link pins come from another domain; all pass two flops.
module pdc_dram_end
  import pdc_pkg::*;
(
  // clock and reset
  input  logic          i_clk,
  input  logic          i_reset,
  // link from controller
  pdc_link_if.dram      link,
  // status
  output pdc_state_type o_state,
  output logic          o_buffers_on,
  output logic          o_dll_frozen,
  output logic          o_slow_exit,
  output logic          o_odt,
  output logic          o_illegal
);

  pdc_pins_type     meta;
  pdc_pins_type     p;
  logic             ck_prev;
  logic             rise;
  logic             cke_prev;
  logic             nop;
  logic             run_cmd;
  pdc_mode_type     mode;
  logic [3:0]       open_rows;
  logic [CNT_W-1:0] busy_cnt;
  logic             ap_pend;
  logic [1:0]       ap_bank;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta    <= '0;
      p       <= '0;
      ck_prev <= 1'b0;
    end else begin
      meta    <= {link.ck, link.cke, link.cmd_n, link.ba, link.a10, link.a12, link.odt};
      p       <= meta;
      ck_prev <= p.ck;
    end
  end

  // pins are launched half a period before the edge, so one sample is safe
  assign rise    = p.ck && !ck_prev;
  assign nop     = pdc_is_nop(p.cmd_n);
  assign run_cmd = rise && cke_prev && p.cke && (mode == M_RUN);

  // ---------------------------------------------------------------
  // power mode and legality
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mode      <= M_RUN;
      cke_prev  <= RST_CKE;
      o_illegal <= 1'b0;
    end else if (rise) begin
      cke_prev <= p.cke;
      if (cke_prev && !p.cke) begin
        if (nop && busy_cnt == '0 && mode == M_RUN) begin
          mode <= M_PD;
        end else if (p.cmd_n == CMD_REF && busy_cnt == '0 && open_rows == 4'h0) begin
          mode <= M_SR;
        end else begin
          o_illegal <= 1'b1;
        end
      end else if (!cke_prev && p.cke) begin
        if (!nop || mode == M_RUN) o_illegal <= 1'b1;
        mode <= M_RUN;
      end else if (run_cmd) begin
        // refresh or load with rows open
        if ((p.cmd_n == CMD_REF || p.cmd_n == CMD_LM) && open_rows != 4'h0) begin
          o_illegal <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // banks, burst completion, mode register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      open_rows   <= 4'h0;
      busy_cnt    <= '0;
      ap_pend     <= 1'b0;
      ap_bank     <= 2'h0;
      o_slow_exit <= 1'b0;
    end else if (rise) begin
      busy_cnt <= pdc_step(busy_cnt, 0);
      // auto precharge closes at recovery end
      if (ap_pend && busy_cnt == CNT_W'(1)) begin
        open_rows[ap_bank] <= 1'b0;
        ap_pend            <= 1'b0;
      end
      if (run_cmd) begin
        for (int b = 0; b < 4; b++) begin
          // act and pre leave no entry wait
          if (p.cmd_n == CMD_ACT && p.ba == 2'(b)) open_rows[b] <= 1'b1;
          if (p.cmd_n == CMD_PRE && (p.a10 || p.ba == 2'(b))) open_rows[b] <= 1'b0;
        end
        if (p.cmd_n == CMD_RD || p.cmd_n == CMD_WR) begin
          busy_cnt <= pdc_step(busy_cnt, (p.cmd_n == CMD_RD) ? RD_DONE_CK : WR_DONE_CK);
          ap_pend  <= p.a10;
          ap_bank  <= p.ba;
        end
        if (p.cmd_n == CMD_LM) begin
          busy_cnt <= pdc_step(busy_cnt, MRD_CK - 1);
          if (p.ba == MR_BANK) o_slow_exit <= p.a12;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_state      <= ST_IDLE;
      o_buffers_on <= 1'b1;
      o_dll_frozen <= 1'b0;
      o_odt        <= 1'b0;
    end else begin
      o_state      <= pdc_state_of(mode, open_rows != 4'h0);
      // buffers off, clock cke odt stay live
      o_buffers_on <= (mode == M_RUN);
      o_odt        <= p.odt;
      o_dll_frozen <= (mode == M_PD) && (open_rows == 4'h0);
    end
  end

endmodule : pdc_dram_end

/* File: pdc_ctrl_end.sv */
// pdc_ctrl_end: controller end that steers cke, commands and link clock.
// assumes one request at a time from user logic on the same clock.
module pdc_ctrl_end
  import pdc_pkg::*;
(
  // clock and reset
  input  logic          i_clk,
  input  logic          i_reset,
  // user request
  input  logic          i_valid,
  input  pdc_op_type    i_op,
  input  logic [1:0]    i_bank,
  input  logic          i_a10,
  input  logic          i_a12,
  input  logic          i_odt,
  input  logic          i_dll_locked,
  // user answer
  output logic          o_ready,
  output logic          o_done,
  output logic          o_refused,
  output pdc_state_type o_state,
  output logic          o_freq_change_ok,
  output logic          o_dll_reset_due,
  // memory link
  pdc_link_if.ctrl      link
);

  logic [PH_W-1:0]  ph;
  logic             launch;
  pdc_mode_type     mode;
  logic             pend;
  pdc_op_type       op;
  logic [1:0]       bank;
  logic             a10;
  logic             a12;
  logic [3:0]       open_rows;
  logic             mr_slow;
  logic [CNT_W-1:0] busy_cnt;
  logic [CNT_W-1:0] xp_cnt;
  logic [CNT_W-1:0] rd_cnt;
  logic [CNT_W-1:0] cke_cnt;
  logic [CNT_W-1:0] refi_cnt;
  logic             legal;
  logic             timing_ok;
  logic             issue;
  logic             refuse;
  logic             force_exit;
  int               exit_rd_gap;
  int               busy_load;
  int               xp_load;
  int               rd_load;
  int               cke_load;

  // ---------------------------------------------------------------
  // link clock divider
  // ---------------------------------------------------------------
  // pins other than odt change with the falling link edge, half a period of margin
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ph      <= '0;
      link.ck <= 1'b0;
    end else begin
      ph      <= ph + PH_W'(1);
      link.ck <= (ph < PH_W'(CK_HALF));
    end
  end

  assign launch = (ph == PH_W'(CK_HALF));

  // ---------------------------------------------------------------
  // request holding
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pend    <= 1'b0;
      o_ready <= 1'b1;
      op      <= OP_NOP;
      bank    <= 2'h0;
      a10     <= 1'b0;
      a12     <= 1'b0;
    end else if (i_valid && o_ready) begin
      pend    <= 1'b1;
      o_ready <= 1'b0;
      op      <= i_op;
      bank    <= i_bank;
      a10     <= i_a10;
      a12     <= i_a12;
    end else if (issue || refuse) begin
      pend    <= 1'b0;
      o_ready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // legality and timing
  // ---------------------------------------------------------------
  always_comb begin
    legal = 1'b0;
    unique case (op)
      OP_PD_EXIT: legal = (mode == M_PD);
      OP_SR_EXIT: legal = (mode == M_SR);
      OP_SR_ENTER, OP_REF, OP_LM: legal = (mode == M_RUN) && (open_rows == 4'h0);
      // reads held off until loop reset
      OP_READ: legal = (mode == M_RUN) && !o_dll_reset_due;
      default: legal = (mode == M_RUN);
    endcase
  end

  always_comb begin
    timing_ok = 1'b0;
    unique case (op)
      OP_NOP: timing_ok = 1'b1;
      // read after exit waits its own delay
      OP_READ: timing_ok = (rd_cnt == '0);
      // no drop during load or burst
      OP_PD_ENTER: timing_ok = (busy_cnt == '0) && (cke_cnt == '0);
      OP_SR_ENTER: timing_ok = (busy_cnt == '0) && (cke_cnt == '0) && (xp_cnt == '0);
      OP_PD_EXIT, OP_SR_EXIT: timing_ok = (cke_cnt == '0);
      // only nops during power-down or self refresh exit
      default: timing_ok = (xp_cnt == '0);
    endcase
  end

  assign force_exit = launch && (mode == M_PD) && (refi_cnt == '0) && (cke_cnt == '0);
  assign issue      = launch && pend && legal && timing_ok && !force_exit;
  assign refuse     = launch && pend && !legal && !force_exit;

  // slow or fast exit from active power-down
  assign exit_rd_gap = (open_rows == 4'h0) ? XP_CK - 1 :
                       (mr_slow ? XARDS_CK - 1 : XARD_CK - 1);

  always_comb begin
    busy_load = 0;
    xp_load   = 0;
    rd_load   = 0;
    cke_load  = 0;
    if (force_exit) begin
      cke_load = CKE_MIN_CK - 1;
      xp_load  = XP_CK - 1;
      rd_load  = exit_rd_gap;
    end else if (issue) begin
      unique case (op)
        OP_READ: busy_load = RD_DONE_CK;
        OP_WRITE: begin
          // entry after write recovery plus one
          busy_load = WR_DONE_CK;
          rd_load   = WR_RD_CK - 1;
        end
        OP_LM: begin
          busy_load = MRD_CK - 1;
          xp_load   = MRD_CK - 1;
          rd_load   = MRD_CK - 1;
        end
        OP_PD_ENTER, OP_SR_ENTER: cke_load = CKE_MIN_CK - 1;
        OP_PD_EXIT: begin
          cke_load = CKE_MIN_CK - 1;
          xp_load  = XP_CK - 1;
          rd_load  = exit_rd_gap;
        end
        OP_SR_EXIT: begin
          cke_load = CKE_MIN_CK - 1;
          xp_load  = XSNR_CK - 1;
          rd_load  = XSRD_CK - 1;
        end
        // act, ref, pre add no entry wait
        default: busy_load = 0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // gap counters, one step per link clock
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_cnt <= '0;
      xp_cnt   <= '0;
      rd_cnt   <= '0;
      cke_cnt  <= '0;
      refi_cnt <= '0;
    end else if (launch) begin
      busy_cnt <= pdc_step(busy_cnt, busy_load);
      xp_cnt   <= pdc_step(xp_cnt, xp_load);
      rd_cnt   <= pdc_step(rd_cnt, rd_load);
      cke_cnt  <= pdc_step(cke_cnt, cke_load);
      if (issue && op == OP_PD_ENTER) refi_cnt <= CNT_W'(REFI_CK - 1);
      else refi_cnt <= pdc_step(refi_cnt, 0);
    end
  end

  // ---------------------------------------------------------------
  // link pins
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      link.cke   <= RST_CKE;
      link.cmd_n <= CMD_NOP;
      link.ba    <= 2'h0;
      link.a10   <= 1'b0;
      link.a12   <= 1'b0;
    end else if (launch) begin
      link.cmd_n <= CMD_NOP;
      link.ba    <= bank;
      link.a10   <= a10;
      link.a12   <= a12;
      if (force_exit) begin
        // exit with nop on rising cke
        link.cke <= 1'b1;
      end else if (issue) begin
        unique case (op)
          OP_ACT:   link.cmd_n <= CMD_ACT;
          OP_READ:  link.cmd_n <= CMD_RD;
          OP_WRITE: link.cmd_n <= CMD_WR;
          OP_PRE:   link.cmd_n <= CMD_PRE;
          OP_REF:   link.cmd_n <= CMD_REF;
          OP_LM:    link.cmd_n <= CMD_LM;
          // entry with nop on falling cke
          OP_PD_ENTER: link.cke <= 1'b0;
          OP_SR_ENTER: begin
            link.cke   <= 1'b0;
            link.cmd_n <= CMD_REF;
          end
          OP_PD_EXIT, OP_SR_EXIT: link.cke <= 1'b1;
          default: link.cmd_n <= CMD_NOP;
        endcase
      end
    end
  end

  // termination input always at a level
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) link.odt <= 1'b0;
    else link.odt <= (mode != M_SR) && i_odt;
  end

  // ---------------------------------------------------------------
  // state, banks and loop bookkeeping
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mode <= M_RUN;
    end else if (force_exit) begin
      mode <= M_RUN;
    end else if (issue) begin
      if (op == OP_PD_ENTER) mode <= M_PD;
      if (op == OP_SR_ENTER) mode <= M_SR;
      if (op == OP_PD_EXIT || op == OP_SR_EXIT) mode <= M_RUN;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      open_rows <= 4'h0;
      mr_slow   <= 1'b0;
    end else if (issue) begin
      for (int b = 0; b < 4; b++) begin
        if (op == OP_ACT && bank == 2'(b)) open_rows[b] <= 1'b1;
        if (op == OP_PRE && (a10 || bank == 2'(b))) open_rows[b] <= 1'b0;
        if ((op == OP_READ || op == OP_WRITE) && a10 && bank == 2'(b)) open_rows[b] <= 1'b0;
      end
      if (op == OP_LM && bank == MR_BANK) mr_slow <= a12;
    end
  end

  // unlocked loop at power-down entry needs reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) o_dll_reset_due <= 1'b0;
    else if (issue && op == OP_PD_ENTER && !i_dll_locked) o_dll_reset_due <= 1'b1;
    else if (issue && op == OP_LM && bank == MR_BANK) o_dll_reset_due <= 1'b0;
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_done           <= 1'b0;
      o_refused        <= 1'b0;
      o_state          <= ST_IDLE;
      o_freq_change_ok <= 1'b0;
    end else begin
      o_done           <= issue;
      o_refused        <= refuse;
      o_state          <= pdc_state_of(mode, open_rows != 4'h0);
      o_freq_change_ok <= (mode == M_PD) && (open_rows == 4'h0);
    end
  end

endmodule : pdc_ctrl_end

/* File: pdc_monitor.sv */
// pdc_monitor: timing checks on the link between the two ends.
// assumes link pins change only just after i_clk edges.
module pdc_monitor
  import pdc_pkg::*;
(
  // clock and reset
  input logic       i_clk,
  input logic       i_reset,
  // link pins
  input logic       ck,
  input logic       cke,
  input logic [3:0] cmd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = CKE_MIN_CK * CK_DIV;
  logic nop;
  logic ck_q;
  logic cke_q;
  logic sr;
  int   cnt;
  int   busy;
  assign nop = cmd_n[3] || (cmd_n == CMD_NOP);
  // ------
  // cycles since cke last moved
  // ------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ck_q  <= 1'b0;
      cke_q <= 1'b1;
      cnt   <= 'hFFFF;
      sr    <= 1'b0;
    end else begin
      ck_q  <= ck;
      cke_q <= cke;
      cnt   <= (cke != cke_q) ? 1 : cnt + 1;
      if (cke_q && !cke) sr <= (cmd_n == CMD_REF);
    end
  end
  // bursts and loads keep cke up far longer than row commands
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) busy <= 0;
    else if (ck_q && !ck && !nop)
      busy <= (cmd_n == CMD_RD) ? (RD_DONE_CK + 1) * CK_DIV - 1 :
              (cmd_n == CMD_WR) ? (WR_DONE_CK + 1) * CK_DIV - 1 :
              (cmd_n == CMD_LM) ? MRD_CK * CK_DIV - 1 : CK_DIV - 1;
    else if (busy != 0) busy <= busy - 1;
  end
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_fall_nop; $fell(cke) |-> (nop || cmd_n == CMD_REF); endproperty
  a_fall_nop: assert property (p_fall_nop) else $error("cke fell with bad command");
  property p_rise_nop; $rose(cke) |-> nop; endproperty
  a_rise_nop: assert property (p_rise_nop) else $error("cke rose with bad command");
  property p_hold; $changed(cke) |-> cnt >= HOLD; endproperty
  a_hold: assert property (p_hold) else $error("cke level held too briefly");
  property p_on_fall; ($changed(cke) || $changed(cmd_n)) |-> $fell(ck); endproperty
  a_on_fall: assert property (p_on_fall) else $error("pins moved off ck fall");
  property p_ck_half; $rose(ck) |=> $stable(ck) [*3] ##1 $fell(ck); endproperty
  a_ck_half: assert property (p_ck_half) else $error("link clock period wrong");
  property p_exit_nop; (cke && cnt < (sr ? XSNR_CK : XP_CK) * CK_DIV) |-> nop; endproperty
  a_exit_nop: assert property (p_exit_nop) else $error("command too soon after exit");
  property p_sr_read; (ck_q && !ck && cmd_n == CMD_RD && sr) |-> cnt >= XSRD_CK * CK_DIV; endproperty
  a_sr_read: assert property (p_sr_read) else $error("read too soon after self refresh");
  property p_busy; $fell(cke) |-> busy == 0; endproperty
  a_busy: assert property (p_busy) else $error("cke fell during an operation");
  c_pd: cover property ($fell(cke) && nop);
  c_sr: cover property ($fell(cke) && cmd_n == CMD_REF);
  c_rd: cover property (ck_q && !ck && cmd_n == CMD_RD);
endmodule : pdc_monitor

/* File: tb_power_down_cke_control.sv */
// tb_power_down_cke_control: both ends joined, user side driven.
// assumes package timing defaults; a second link is driven badly.
module tb_power_down_cke_control
  import pdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          i_clk, i_reset, i_valid, i_a10, i_a12, i_odt, i_dll_locked;
  pdc_op_type    i_op;
  logic [1:0]    i_bank;
  logic          o_ready, o_done, o_refused, o_freq_change_ok, o_dll_reset_due;
  pdc_state_type o_state, d_state;
  logic          d_buf, d_frz, d_slow, d_odt, d_ill, b_ill;
  int            mismatches, n_tests;
  pdc_link_if link_if();
  pdc_link_if bad_if();
  pdc_ctrl_end pdc_ctrl_end_inst(.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid),
    .i_op(i_op), .i_bank(i_bank), .i_a10(i_a10), .i_a12(i_a12), .i_odt(i_odt),
    .i_dll_locked(i_dll_locked), .o_ready(o_ready), .o_done(o_done), .o_refused(o_refused),
    .o_state(o_state), .o_freq_change_ok(o_freq_change_ok),
    .o_dll_reset_due(o_dll_reset_due), .link(link_if.ctrl));
  pdc_dram_end pdc_dram_end_inst(.i_clk(i_clk), .i_reset(i_reset), .link(link_if.dram),
    .o_state(d_state), .o_buffers_on(d_buf), .o_dll_frozen(d_frz), .o_slow_exit(d_slow),
    .o_odt(d_odt), .o_illegal(d_ill));
  pdc_dram_end pdc_dram_end_inst2(.i_clk(i_clk), .i_reset(i_reset), .link(bad_if.dram),
    .o_state(), .o_buffers_on(), .o_dll_frozen(), .o_slow_exit(), .o_odt(),
    .o_illegal(b_ill));
  pdc_monitor pdc_monitor_inst(.i_clk(i_clk), .i_reset(i_reset), .ck(link_if.ck),
    .cke(link_if.cke), .cmd_n(link_if.cmd_n));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    bad_if.ck = 1'b0;
    forever #32 bad_if.ck = ~bad_if.ck;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one request, then wait for its done or refused pulse
  task automatic req(input pdc_op_type op, input logic [1:0] bank, input logic ok);
    int k;
    while (o_ready !== 1'b1) @(negedge i_clk);
    i_valid = 1'b1;
    i_op = op;
    i_bank = bank;
    @(negedge i_clk);
    i_valid = 1'b0;
    for (k = 0; k < 2000 && o_done !== 1'b1 && o_refused !== 1'b1; k++) @(negedge i_clk);
    chk("answer", {2'h0, ok, !ok}, {2'h0, o_done, o_refused});
  endtask : req
  task automatic mem(input pdc_state_type s, input logic buf_on);
    repeat (16) @(negedge i_clk);
    chk("mem_state", 4'(s), 4'(d_state));
    chk("ctrl_state", 4'(s), 4'(o_state));
    chk("buffers", 4'(buf_on), 4'(d_buf));
  endtask : mem
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {i_reset, i_valid, i_a10, i_a12, i_odt, i_dll_locked} = 6'h21;
    i_op = OP_NOP;
    i_bank = 2'h0;
    mismatches = 0;
    n_tests = 0;
    // idle link: cke high, deselect, all else low
    {bad_if.cke, bad_if.cmd_n, bad_if.ba, bad_if.a10, bad_if.a12, bad_if.odt} = 10'h3E0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    mem(ST_IDLE, 1'b1);
    req(OP_PD_ENTER, 2'h0, 1'b1);
    mem(ST_PRE_PD, 1'b0);
    chk("frozen", 4'h1, 4'(d_frz));
    chk("freq_ok", 4'h1, 4'(o_freq_change_ok));
    i_odt = 1'b1;
    repeat (24) @(negedge i_clk);
    chk("odt", 4'h1, 4'(d_odt));
    i_odt = 1'b0;
    req(OP_READ, 2'h0, 1'b0);
    req(OP_PD_EXIT, 2'h0, 1'b1);
    mem(ST_IDLE, 1'b1);
    req(OP_PD_EXIT, 2'h0, 1'b0);
    i_a12 = 1'b1;
    req(OP_LM, 2'h0, 1'b1);
    i_a12 = 1'b0;
    req(OP_PD_ENTER, 2'h0, 1'b1);
    mem(ST_PRE_PD, 1'b0);
    chk("slow_exit", 4'h1, 4'(d_slow));
    req(OP_PD_EXIT, 2'h0, 1'b1);
    req(OP_ACT, 2'h1, 1'b1);
    req(OP_PD_ENTER, 2'h0, 1'b1);
    mem(ST_ACT_PD, 1'b0);
    chk("frozen", 4'h0, 4'(d_frz));
    chk("freq_ok", 4'h0, 4'(o_freq_change_ok));
    req(OP_PD_EXIT, 2'h0, 1'b1);
    req(OP_READ, 2'h1, 1'b1);
    req(OP_SR_ENTER, 2'h0, 1'b0);
    i_a10 = 1'b1;
    req(OP_WRITE, 2'h1, 1'b1);
    i_a10 = 1'b0;
    req(OP_PD_ENTER, 2'h0, 1'b1);
    mem(ST_PRE_PD, 1'b0);
    req(OP_PD_EXIT, 2'h0, 1'b1);
    req(OP_SR_ENTER, 2'h0, 1'b1);
    mem(ST_SELF_REF, 1'b0);
    req(OP_READ, 2'h0, 1'b0);
    req(OP_SR_EXIT, 2'h0, 1'b1);
    req(OP_ACT, 2'h2, 1'b1);
    req(OP_READ, 2'h2, 1'b1);
    i_a10 = 1'b1;
    req(OP_PRE, 2'h0, 1'b1);
    i_a10 = 1'b0;
    i_dll_locked = 1'b0;
    req(OP_PD_ENTER, 2'h0, 1'b1);
    req(OP_PD_EXIT, 2'h0, 1'b1);
    chk("dll_due", 4'h1, 4'(o_dll_reset_due));
    req(OP_READ, 2'h0, 1'b0);
    i_dll_locked = 1'b1;
    req(OP_LM, 2'h0, 1'b1);
    chk("dll_due", 4'h0, 4'(o_dll_reset_due));
    req(OP_PD_ENTER, 2'h0, 1'b1);
    repeat (1100) @(negedge i_clk);
    mem(ST_IDLE, 1'b1);
    chk("illegal", 4'h0, 4'(d_ill));
    @(negedge bad_if.ck);
    bad_if.cke = 1'b0;
    bad_if.cmd_n = CMD_RD;
    @(negedge bad_if.ck);
    bad_if.cmd_n = CMD_NOP;
    repeat (3) @(negedge bad_if.ck);
    chk("bad_illegal", 4'h1, 4'(b_ill));
    report_and_stop();
  end
endmodule : tb_power_down_cke_control
